// file: sdwc_pkg.sv
//==================================================
// Shared constants
//==================================================
package sdwc_pkg;
   localparam int unsigned FRAME_BITS   = 16;
   localparam int unsigned MODE_HI_POS  = 13;
   localparam int unsigned MODE_LO_POS  = 12;
   localparam int unsigned CODE_MSB_POS = 11;
   localparam int unsigned CODE_LSB_POS = 4;
   localparam logic [7:0]  CODE_RESET   = 8'h00;
   localparam logic [1:0]  MODE_RESET   = 2'h0;
   localparam logic [1:0]  MODE_NORMAL  = 2'h0;
   localparam logic [1:0]  MODE_PD_1K   = 2'h1;
   localparam logic [1:0]  MODE_PD_100K = 2'h2;
   localparam logic [1:0]  MODE_PD_OPEN = 2'h3;
   localparam int unsigned SCLK_HALF_DIV = 4;
   localparam int unsigned SYNC_IDLE_CYCLES = 2;
   localparam logic [7:0]  REG_ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  REG_ADDR_STATUS = 8'h04;
   localparam logic [7:0]  REG_ADDR_LAST   = 8'h08;
   localparam int unsigned CTRL_MODE_POS   = 8;
   localparam int unsigned CTRL_PARK_POS   = 10;
endpackage : sdwc_pkg

// file: sdwc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
//==================================================
// Three-wire write-only link
//==================================================
interface sdwc_link_if;
   logic syncN;
   logic sclk;
   logic sdata;
   modport host   (output syncN, output sclk, output sdata);
   modport device (input syncN, input sclk, input sdata);
endinterface : sdwc_link_if
`default_nettype wire

// file: sdwc_device.sv
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sdwc_device
   import sdwc_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_n,
   sdwc_link_if.device    link,
   output var  logic [7:0] dacCode,
   output var  logic [1:0] opMode,
   output var  logic       ampEnable,
   output var  logic       load1kEnable,
   output var  logic       load100kEnable,
   output var  logic       frameApplied
);
   //==================================================
   // Input synchronisers
   //==================================================
   logic [1:0] syncSh_r;
   logic [1:0] sclkSh_r;
   logic [1:0] dataSh_r;
   logic       syncPrev_r;
   logic       sclkPrev_r;

   // Frame select, idles high, no false fall after reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         syncSh_r   <= 2'h3;
         syncPrev_r <= 1'b1;
      end
      else
      begin
         syncSh_r   <= {syncSh_r[0], link.syncN};
         syncPrev_r <= syncSh_r[1];
      end
   end

   // Serial clock, idles low
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclkSh_r   <= 2'h0;
         sclkPrev_r <= 1'b0;
      end
      else
      begin
         sclkSh_r   <= {sclkSh_r[0], link.sclk};
         sclkPrev_r <= sclkSh_r[1];
      end
   end

   // Serial data, same latency as the clock
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dataSh_r <= 2'h0;
      end
      else
      begin
         dataSh_r <= {dataSh_r[0], link.sdata};
      end
   end

   logic syncLow;
   logic syncFall;
   logic sclkFall;
   assign syncLow  = ~syncSh_r[1];
   assign syncFall = syncPrev_r & ~syncSh_r[1];
   assign sclkFall = sclkPrev_r & ~sclkSh_r[1];

   //==================================================
   // Shift register and frame tracking
   //==================================================
   logic [15:0] shift_r;
   logic [4:0]  count_r;
   logic        armed_r;
   logic [15:0] shiftNxt;
   logic        lastEdge;

   assign shiftNxt = {shift_r[14:0], dataSh_r[1]};
   assign lastEdge = armed_r & syncLow & sclkFall & (count_r == 5'(FRAME_BITS - 1));

   // Shift register, cleared outside a frame
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_r <= 16'h0000;
      end
      else if (!syncLow || syncFall)
      begin
         shift_r <= 16'h0000;
      end
      else if (armed_r && sclkFall)
      begin
         shift_r <= shiftNxt;
      end
   end

   // Falling edge counter
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_r <= 5'h00;
      end
      else if (!syncLow || syncFall)
      begin
         count_r <= 5'h00;
      end
      else if (armed_r && sclkFall)
      begin
         count_r <= count_r + 5'h01;
      end
   end

   // Frame armed from select fall until applied or until select rises
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         armed_r <= 1'b0;
      end
      else if (!syncLow)
      begin
         armed_r <= 1'b0;
      end
      else if (syncFall)
      begin
         armed_r <= 1'b1;
      end
      else if (lastEdge)
      begin
         armed_r <= 1'b0;
      end
   end

   //==================================================
   // Converter register and mode
   //==================================================
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dacCode      <= CODE_RESET;
         opMode       <= MODE_RESET;
         frameApplied <= 1'b0;
      end
      else
      begin
         frameApplied <= lastEdge;
         if (lastEdge)
         begin
            dacCode <= shiftNxt[CODE_MSB_POS:CODE_LSB_POS];
            opMode  <= shiftNxt[MODE_HI_POS:MODE_LO_POS];
         end
      end
   end

   //==================================================
   // Analog control
   //==================================================
   function automatic logic sdwc_mode_is(input logic [1:0] mode, input logic [1:0] sel);
      return (mode == sel);
   endfunction : sdwc_mode_is

   // Follows the mode one clock late
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ampEnable      <= 1'b1;
         load1kEnable   <= 1'b0;
         load100kEnable <= 1'b0;
      end
      else
      begin
         ampEnable      <= sdwc_mode_is(opMode, MODE_NORMAL);
         load1kEnable   <= sdwc_mode_is(opMode, MODE_PD_1K);
         load100kEnable <= sdwc_mode_is(opMode, MODE_PD_100K);
      end
   end
endmodule : sdwc_device
`default_nettype wire

// file: sdwc_host.sv
`timescale 1ns/1ps
`default_nettype none
module sdwc_host
   import sdwc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   sdwc_link_if.host       link,
   input  wire logic [7:0] addr,
   input  wire logic [31:0] wrData,
   input  wire logic       wrStb,
   input  wire logic       rdStb,
   output var  logic [31:0] rdData
);
   //==================================================
   // Host state
   //==================================================
   typedef enum logic [1:0] {IDLE, PRESEL, SHIFT, DONE} sdwc_state_e;
   sdwc_state_e state_r;
   logic [15:0] word_r;
   logic [15:0] last_r;
   logic [4:0]  bits_r;
   logic [2:0]  div_r;
   logic        pend_r;
   logic        park_r;
   logic        syncN_r;
   logic        sclk_r;
   logic        sdata_r;

   assign link.syncN = syncN_r;
   assign link.sclk  = sclk_r;
   assign link.sdata = sdata_r;

   function automatic logic [15:0] sdwc_build(input logic [31:0] d);
      logic [15:0] w;
      w = 16'h0000;
      w[MODE_HI_POS:MODE_LO_POS]   = d[CTRL_MODE_POS +: 2];
      w[CODE_MSB_POS:CODE_LSB_POS] = d[7:0];
      return w;
   endfunction : sdwc_build

   //==================================================
   // Register port
   //==================================================
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdData <= 32'h0000_0000;
      end
      else if (rdStb)
      begin
         unique case (addr)
            REG_ADDR_STATUS: rdData <= {30'h0, state_r != IDLE, pend_r};
            REG_ADDR_LAST:   rdData <= {16'h0, last_r};
            REG_ADDR_CTRL:   rdData <= 32'(park_r) << CTRL_PARK_POS;
            default:         rdData <= 32'h0000_0000;
         endcase
      end
      else
      begin
         rdData <= 32'h0000_0000;
      end
   end

   //==================================================
   // Serial engine
   //==================================================
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= IDLE;
         word_r  <= 16'h0000;
         last_r  <= 16'h0000;
         bits_r  <= 5'h00;
         div_r   <= 3'h0;
         pend_r  <= 1'b0;
         park_r  <= 1'b0;
         syncN_r <= 1'b1;
         sclk_r  <= 1'b0;
         sdata_r <= 1'b0;
      end
      else
      begin
         if (wrStb && addr == REG_ADDR_CTRL && !pend_r && state_r == IDLE)
         begin
            word_r <= sdwc_build(wrData);
            park_r <= wrData[CTRL_PARK_POS];
            pend_r <= 1'b1;
         end
         unique case (state_r)
            IDLE:
            begin
               if (pend_r)
               begin
                  syncN_r <= 1'b1;
                  last_r  <= word_r;
                  div_r   <= 3'h0;
                  state_r <= PRESEL;
               end
            end
            PRESEL:
            begin
               div_r <= div_r + 3'h1;
               if (div_r == 3'(SYNC_IDLE_CYCLES))
               begin
                  syncN_r <= 1'b0;
                  sdata_r <= word_r[15];
                  bits_r  <= 5'h00;
                  div_r   <= 3'h0;
                  state_r <= SHIFT;
               end
            end
            SHIFT:
            begin
               div_r <= div_r + 3'h1;
               if (div_r == 3'(SCLK_HALF_DIV - 1))
               begin
                  div_r  <= 3'h0;
                  sclk_r <= ~sclk_r;
                  if (sclk_r)
                  begin
                     bits_r <= bits_r + 5'h01;
                     word_r <= {word_r[14:0], 1'b0};
                     if (bits_r == 5'(FRAME_BITS - 1))
                     begin
                        state_r <= DONE;
                     end
                  end
                  else
                  begin
                     sdata_r <= word_r[15];
                  end
               end
            end
            DONE:
            begin
               div_r <= div_r + 3'h1;
               if (div_r == 3'(SCLK_HALF_DIV - 1))
               begin
                  syncN_r <= park_r ? 1'b0 : 1'b1;
                  pend_r  <= 1'b0;
                  state_r <= IDLE;
               end
            end
         endcase
      end
   end
endmodule : sdwc_host
`default_nettype wire

// file: sdwc_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
//====================
// Link checks
module sdwc_link_sva
   import sdwc_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       syncN,
   input wire logic       sclk,
   input wire logic       sdata,
   input wire logic [7:0] dacCode,
   input wire logic [1:0] opMode,
   input wire logic       ampEnable,
   input wire logic       load1kEnable,
   input wire logic       load100kEnable,
   input wire logic       frameApplied
);
   logic        sclkD_r;
   logic [4:0]  cnt_r;
   logic [15:0] cap_r;
   wire         fall = sclkD_r & ~sclk & ~syncN;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) sclkD_r <= 1'b0;
      else sclkD_r <= sclk;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) cnt_r <= 5'h00;
      else if (syncN) cnt_r <= 5'h00;
      else if (fall) cnt_r <= cnt_r + 5'h01;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) cap_r <= 16'h0000;
      else if (fall) cap_r <= {cap_r[14:0], sdata};
   sequence seqPulse;
      frameApplied ##1 !frameApplied;
   endsequence
   AST_PULSE: assert property (frameApplied |-> seqPulse)
      else $error("apply pulse too long");
   AST_COUNT: assert property (frameApplied |-> cnt_r == 5'h10)
      else $error("apply not at edge 16");
   AST_DATA: assert property (frameApplied |-> dacCode == cap_r[11:4] && opMode == cap_r[13:12])
      else $error("applied word wrong");
   AST_CODE: assert property ($changed(dacCode) |-> frameApplied)
      else $error("code moved alone");
   AST_MODE: assert property ($changed(opMode) |-> frameApplied)
      else $error("mode moved alone");
   AST_AMP: assert property (ampEnable == ($past(opMode) == MODE_NORMAL))
      else $error("amp enable wrong");
   AST_LOAD: assert property (load1kEnable == ($past(opMode) == MODE_PD_1K)
      && load100kEnable == ($past(opMode) == MODE_PD_100K))
      else $error("load select wrong");
   AST_SEL: assert property ($fell(syncN) |-> $past(syncN, 2) && $past(syncN, 3) && !sclk)
      else $error("frame start wrong");
   AST_EXTRA: assert property (cnt_r <= 5'h10)
      else $error("too many clock edges");
endmodule : sdwc_link_sva
`default_nettype wire

// file: test_serial_dac_write_control.sv
`timescale 1ns/1ps
`default_nettype none
//====================
// Bench
module test_serial_dac_write_control
   import sdwc_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wrData = 32'h0;
   logic        wrStb = 1'b0;
   logic        rdStb = 1'b0;
   logic [31:0] rdData, d;
   logic [7:0]  dacCode, codeB;
   logic [1:0]  opMode, modeB;
   logic        ampEnable, load1kEnable, load100kEnable, frameApplied, appB;
   int          num_errors = 0;
   int          tests_run = 0;
   int          nB = 0;
   sdwc_link_if link();
   sdwc_link_if linkB();
   sdwc_host u_sdwc_host (.clk, .rst_n, .link(link), .addr, .wrData, .wrStb, .rdStb, .rdData);
   sdwc_device u_sdwc_device (.clk, .rst_n, .link(link), .dacCode, .opMode, .ampEnable,
      .load1kEnable, .load100kEnable, .frameApplied);
   sdwc_device u_sdwc_device_b (.clk, .rst_n, .link(linkB), .dacCode(codeB), .opMode(modeB),
      .ampEnable(), .load1kEnable(), .load100kEnable(), .frameApplied(appB));
   sdwc_link_sva u_sdwc_link_sva (.clk, .rst_n, .syncN(link.syncN), .sclk(link.sclk),
      .sdata(link.sdata), .dacCode, .opMode, .ampEnable, .load1kEnable, .load100kEnable, .frameApplied);
   always #20 clk = ~clk;
   always @(negedge clk) if (appB === 1'b1) nB++;
   task automatic chk(string w, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) $display("wrong value %s exp %h got %h", w, e, g);
      if (g !== e) num_errors++;
   endtask : chk
   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wrData <= v;
      wrStb <= 1'b1;
      @(posedge clk);
      wrStb <= 1'b0;
   endtask : wr
   task automatic rd(logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge clk);
      rdStb <= 1'b0;
      #1 v = rdData;
   endtask : rd
   task automatic expect_frame(logic [1:0] m, logic [7:0] c, logic p);
      int n;
      n = 0;
      while (frameApplied !== 1'b1 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      chk("apply", 1, frameApplied);
      chk("code", c, dacCode);
      chk("mode", m, opMode);
      @(negedge clk);
      chk("amp", m == MODE_NORMAL, ampEnable);
      chk("load", {m == MODE_PD_100K, m == MODE_PD_1K}, {load100kEnable, load1kEnable});
      n = 0;
      do
      begin
         rd(REG_ADDR_STATUS, d);
         n++;
      end
      while (d[1:0] !== 2'h0 && n < 50);
      chk("idle", 0, d[1:0]);
      chk("select", !p, link.syncN);
      rd(REG_ADDR_LAST, d);
      chk("last", {18'h0, m, c, 4'h0}, d);
   endtask : expect_frame
   task automatic bang(logic [15:0] w, int falls);
      @(posedge clk);
      linkB.syncN <= 1'b0;
      for (int i = 0; i < falls; i++)
      begin
         repeat (4) @(posedge clk);
         linkB.sclk <= 1'b1;
         linkB.sdata <= w[15 - (i % 16)];
         repeat (4) @(posedge clk);
         linkB.sclk <= 1'b0;
      end
      repeat (8) @(posedge clk);
      linkB.syncN <= 1'b1;
      linkB.sdata <= ~linkB.sdata;
      repeat (8) @(posedge clk);
   endtask : bang
   task print_verdict();
      if (num_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   initial
   begin
      linkB.syncN <= 1'b1;
      linkB.sclk <= 1'b0;
      linkB.sdata <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("code", 0, dacCode);
      chk("mode", 0, opMode);
      chk("amp", 1, ampEnable);
      for (int i = 0; i < 4; i++)
      begin
         wr(REG_ADDR_CTRL, {21'h0, i[0], i[1:0], 8'hff >> (2 * i)});
         expect_frame(i[1:0], 8'hff >> (2 * i), i[0]);
      end
      wr(REG_ADDR_CTRL, 32'h0000_0480);
      wr(REG_ADDR_CTRL, 32'h0000_0077);
      rd(REG_ADDR_CTRL, d);
      chk("park", 1, d[10]);
      expect_frame(MODE_NORMAL, 8'h80, 1'b1);
      wr(8'h0c, 32'h0000_0011);
      rd(8'h0c, d);
      chk("unmapped", 0, d);
      repeat (200) @(posedge clk);
      chk("code", 8'h80, dacCode);
      bang(16'he3cf, 48);
      chk("code b", 8'h3c, codeB);
      chk("mode b", 2, modeB);
      chk("count b", 1, nB);
      bang(16'h1c30, 15);
      chk("code b", 8'h3c, codeB);
      chk("mode b", 2, modeB);
      chk("count b", 1, nB);
      print_verdict();
   end
   initial
   begin
      #2000000;
      num_errors++;
      print_verdict();
   end
endmodule : test_serial_dac_write_control
`default_nettype wire
